// file: eac_host.sv
`timescale 1ns/1ns
module eac_host
  import eac_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [2:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  eac_if.host              bus
);

  typedef enum logic [3:0] {
    H_IDLE, H_POLL, H_ADDRH, H_ADDRL, H_DATA, H_MODE, H_ARM, H_FIRE, H_STROBE, H_STALL, H_FETCH
  } eac_state_e;

  eac_state_e        state_reg;
  logic              ack_reg;
  logic [31:0]       rdata_bus_reg;
  logic [2:0]        cmd_reg;
  logic [NVM_AW-1:0] addr_reg;
  logic [7:0]        wdata_reg;
  logic [7:0]        result_reg;
  logic              gie_reg;
  logic              rie_reg;
  logic              wr_take;
  logic              is_read;

  assign avs_waitrequest_o = !ack_reg;
  assign avs_readdata_o    = rdata_bus_reg;
  assign wr_take           = avs_write_i && ack_reg;
  assign is_read           = cmd_reg[CMD_READ_BIT];

  // one wait cycle per access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_bus_reg <= 32'h0;
    end else if (avs_read_i && !ack_reg) begin
      unique case (avs_address_i)
        HOST_CMD:    rdata_bus_reg <= {29'h0, cmd_reg};
        HOST_ADDR:   rdata_bus_reg <= {23'h0, addr_reg};
        HOST_WDATA:  rdata_bus_reg <= {24'h0, wdata_reg};
        HOST_STATUS: rdata_bus_reg <= {29'h0, bus.ready_irq, bus.halt, state_reg != H_IDLE};
        HOST_RDATA:  rdata_bus_reg <= {24'h0, result_reg};
        HOST_CONFIG: rdata_bus_reg <= {30'h0, rie_reg, gie_reg};
        default:     rdata_bus_reg <= 32'h0;
      endcase
    end
  end

  // software registers; a command while busy is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg   <= 3'h0;
      addr_reg  <= '0;
      wdata_reg <= 8'h00;
      gie_reg   <= 1'b0;
      rie_reg   <= 1'b0;
    end else if (wr_take) begin
      if (avs_address_i == HOST_CMD && state_reg == H_IDLE) begin
        cmd_reg <= avs_writedata_i[2:0];
      end
      if (avs_address_i == HOST_ADDR) begin
        addr_reg <= avs_writedata_i[NVM_AW-1:0];
      end
      if (avs_address_i == HOST_WDATA) begin
        wdata_reg <= avs_writedata_i[7:0];
      end
      if (avs_address_i == HOST_CONFIG) begin
        gie_reg <= avs_writedata_i[CFG_GIE_BIT];
        rie_reg <= avs_writedata_i[CFG_RIE_BIT];
      end
    end
  end

  assign bus.gie = gie_reg;

  // access sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg  <= H_IDLE;
      result_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        H_IDLE:   if (wr_take && avs_address_i == HOST_CMD) state_reg <= H_POLL;
        H_POLL:   if (!bus.io_rdata[CTRL_PE_BIT]) state_reg <= H_ADDRH;
        H_ADDRH:  state_reg <= H_ADDRL;
        H_ADDRL:  state_reg <= is_read ? H_STROBE : H_DATA;
        H_DATA:   state_reg <= H_MODE;
        H_MODE:   state_reg <= H_ARM;
        H_ARM:    state_reg <= H_FIRE;
        H_FIRE:   state_reg <= H_STALL;
        H_STROBE: state_reg <= H_STALL;
        H_STALL:  if (!bus.halt) state_reg <= is_read ? H_FETCH : H_IDLE;
        H_FETCH: begin
          result_reg <= bus.io_rdata;
          state_reg  <= H_IDLE;
        end
        default:  state_reg <= H_IDLE;
      endcase
    end
  end

  // I/O strobes decoded from the state
  always_comb begin
    bus.io_wr    = 1'b0;
    bus.io_rd    = 1'b0;
    bus.io_addr  = IO_CTRL;
    bus.io_wdata = 8'h00;
    unique case (state_reg)
      H_POLL:   bus.io_rd = 1'b1;
      H_ADDRH: begin
        bus.io_wr    = 1'b1;
        bus.io_addr  = IO_ADDR_HIGH;
        bus.io_wdata = {7'h00, addr_reg[NVM_AW-1]};
      end
      H_ADDRL: begin
        bus.io_wr    = 1'b1;
        bus.io_addr  = IO_ADDR_LOW;
        bus.io_wdata = addr_reg[7:0];
      end
      H_DATA: begin
        bus.io_wr    = 1'b1;
        bus.io_addr  = IO_DATA;
        bus.io_wdata = wdata_reg;
      end
      H_MODE: begin
        bus.io_wr    = 1'b1;
        bus.io_wdata = ctrl_word(cmd_reg[1:0], rie_reg, 1'b0, 1'b0, 1'b0);
      end
      H_ARM: begin
        bus.io_wr    = 1'b1;
        bus.io_wdata = ctrl_word(cmd_reg[1:0], rie_reg, 1'b1, 1'b0, 1'b0);
      end
      H_FIRE: begin
        bus.io_wr    = 1'b1;
        bus.io_wdata = ctrl_word(cmd_reg[1:0], rie_reg, 1'b1, 1'b1, 1'b0);
      end
      H_STROBE: begin
        bus.io_wr    = 1'b1;
        bus.io_wdata = ctrl_word(2'h0, rie_reg, 1'b0, 1'b0, 1'b1);
      end
      H_FETCH: begin
        bus.io_rd   = 1'b1;
        bus.io_addr = IO_DATA;
      end
      default: begin
        bus.io_wr = 1'b0;
      end
    endcase
  end

endmodule : eac_host

// file: eac_pkg.sv
package eac_pkg;

  // clock and programming times
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_ATOMIC_NS   = 3400000;
  localparam int T_SPLIT_NS    = 1800000;
  localparam int ATOMIC_CYCLES = T_ATOMIC_NS / CLK_PERIOD_NS;
  localparam int SPLIT_CYCLES  = T_SPLIT_NS / CLK_PERIOD_NS;
  localparam int TMR_W         = 18;

  // storage geometry
  localparam int NVM_BYTES = 512;
  localparam int NVM_AW    = 9;

  // device register offsets in I/O space
  localparam logic [1:0] IO_ADDR_HIGH = 2'h0;
  localparam logic [1:0] IO_ADDR_LOW  = 2'h1;
  localparam logic [1:0] IO_DATA      = 2'h2;
  localparam logic [1:0] IO_CTRL      = 2'h3;

  // nvm_control field positions
  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_PE_BIT   = 1;
  localparam int CTRL_MPE_BIT  = 2;
  localparam int CTRL_RIE_BIT  = 3;
  localparam int CTRL_MODE_LO  = 4;
  localparam int CTRL_MODE_HI  = 5;

  // programming modes
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE  = 2'h1;
  localparam logic [1:0] MODE_WRITE  = 2'h2;
  localparam logic [1:0] MODE_RSVD   = 2'h3;

  // reset and erased values, master enable hold and stall counts
  localparam logic [1:0] MODE_RESET  = 2'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [2:0] MPE_HOLD    = 3'h4;
  localparam logic [2:0] HALT_READ   = 3'h4;
  localparam logic [2:0] HALT_PROG   = 3'h2;

  // host register word offsets
  localparam logic [2:0] HOST_CMD    = 3'h0;
  localparam logic [2:0] HOST_ADDR   = 3'h1;
  localparam logic [2:0] HOST_WDATA  = 3'h2;
  localparam logic [2:0] HOST_STATUS = 3'h3;
  localparam logic [2:0] HOST_RDATA  = 3'h4;
  localparam logic [2:0] HOST_CONFIG = 3'h5;

  // host field positions
  localparam int CMD_READ_BIT    = 2;
  localparam int CFG_GIE_BIT     = 0;
  localparam int CFG_RIE_BIT     = 1;
  localparam int STAT_ENGINE_BIT = 0;
  localparam int STAT_HALT_BIT   = 1;
  localparam int STAT_IRQ_BIT    = 2;

  // builds an nvm_control write word
  function automatic logic [7:0] ctrl_word(input logic [1:0] mode, input logic rie, input logic mpe,
                                           input logic pe, input logic rd);
    ctrl_word = {2'h0, mode, rie, mpe, pe, rd};
  endfunction : ctrl_word

endpackage : eac_pkg

// file: eac_if.sv
`timescale 1ns/1ns
interface eac_if;
  logic [1:0] io_addr;
  logic       io_wr;
  logic       io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic       halt;
  logic       ready_irq;
  logic       gie;

  modport dev  (input io_addr, io_wr, io_rd, io_wdata, gie, output io_rdata, halt, ready_irq);
  modport host (output io_addr, io_wr, io_rd, io_wdata, gie, input io_rdata, halt, ready_irq);
endinterface : eac_if

// file: eac_prog_timer.sv
`timescale 1ns/1ns
module eac_prog_timer
  import eac_pkg::*;
#(
  parameter int ATOMIC_P = ATOMIC_CYCLES,
  parameter int SPLIT_P  = SPLIT_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic por_i,
  input  wire logic start_i,
  input  wire logic atomic_i,
  output logic      busy_o,
  output logic      done_o
);

  logic [TMR_W-1:0] cnt_reg;

  // only power-on clears the count, so a system reset lets programming finish
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      cnt_reg <= '0;
    end else if (start_i) begin
      cnt_reg <= atomic_i ? TMR_W'(ATOMIC_P) : TMR_W'(SPLIT_P);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - TMR_W'(1);
    end
  end

  assign busy_o = (cnt_reg != '0);
  assign done_o = (cnt_reg == TMR_W'(1));

endmodule : eac_prog_timer

// file: eac_device.sv
`timescale 1ns/1ns
module eac_device
  import eac_pkg::*;
#(
  parameter int ATOMIC_CYCLES_P = ATOMIC_CYCLES,
  parameter int SPLIT_CYCLES_P  = SPLIT_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic por_i,
  eac_if.dev        bus,
  output logic      nvm_busy_o
);

  logic [7:0]        mem [NVM_BYTES];

  logic              addr_hi_reg;
  logic [7:0]        addr_lo_reg;
  logic [7:0]        data_reg;
  logic [1:0]        mode_reg;
  logic              rie_reg;
  logic              mpe_reg;
  logic [2:0]        mpe_cnt_reg;
  logic [2:0]        halt_cnt_reg;
  logic [1:0]        op_mode_reg;
  logic [NVM_AW-1:0] op_addr_reg;
  logic [7:0]        op_data_reg;

  logic              busy;
  logic              done;
  logic              wr_ctrl;
  logic              start_prog;
  logic              start_read;
  logic [NVM_AW-1:0] addr;

  assign addr    = {addr_hi_reg, addr_lo_reg};
  assign wr_ctrl = bus.io_wr && (bus.io_addr == IO_CTRL);

  // master enable must already be set from an earlier write
  assign start_prog = wr_ctrl && bus.io_wdata[CTRL_PE_BIT] && mpe_reg && !busy
                      && (mode_reg != MODE_RSVD);
  assign start_read = wr_ctrl && bus.io_wdata[CTRL_READ_BIT] && !busy;

  eac_prog_timer #(
    .ATOMIC_P (ATOMIC_CYCLES_P),
    .SPLIT_P  (SPLIT_CYCLES_P)
  ) u_timer (
    .clk_i    (clk_i),
    .por_i    (por_i),
    .start_i  (start_prog),
    .atomic_i (mode_reg == MODE_ATOMIC),
    .busy_o   (busy),
    .done_o   (done)
  );

  assign nvm_busy_o = busy;

  // address registers, frozen while programming
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      addr_hi_reg <= 1'b0;
      addr_lo_reg <= 8'h00;
    end else if (bus.io_wr && !busy) begin
      if (bus.io_addr == IO_ADDR_HIGH) begin
        addr_hi_reg <= bus.io_wdata[0];
      end
      if (bus.io_addr == IO_ADDR_LOW) begin
        addr_lo_reg <= bus.io_wdata;
      end
    end
  end

  // data register: written by software, loaded by a read strobe
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      data_reg <= 8'h00;
    end else if (start_read) begin
      data_reg <= mem[addr];
    end else if (bus.io_wr && (bus.io_addr == IO_DATA)) begin
      data_reg <= bus.io_wdata;
    end
  end

  // programming mode field
  always_ff @(posedge clk_i) begin
    if (por_i || (rst_i && !busy)) begin
      mode_reg <= MODE_RESET;
    end else if (wr_ctrl && !busy && !start_prog) begin
      mode_reg <= bus.io_wdata[CTRL_MODE_HI:CTRL_MODE_LO];
    end
  end

  // ready interrupt enable
  always_ff @(posedge clk_i) begin
    if (por_i || rst_i) begin
      rie_reg <= 1'b0;
    end else if (wr_ctrl) begin
      rie_reg <= bus.io_wdata[CTRL_RIE_BIT];
    end
  end

  // master enable window
  always_ff @(posedge clk_i) begin
    if (por_i || rst_i) begin
      mpe_reg     <= 1'b0;
      mpe_cnt_reg <= 3'h0;
    end else if (wr_ctrl && bus.io_wdata[CTRL_MPE_BIT]) begin
      mpe_reg     <= 1'b1;
      mpe_cnt_reg <= 3'h0;
    end else if (start_prog) begin
      mpe_reg     <= 1'b0;
      mpe_cnt_reg <= 3'h0;
    end else if (mpe_reg) begin
      if (mpe_cnt_reg == MPE_HOLD - 3'h1) begin
        mpe_reg     <= 1'b0;
        mpe_cnt_reg <= 3'h0;
      end else begin
        mpe_cnt_reg <= mpe_cnt_reg + 3'h1;
      end
    end
  end

  // processor stall counter
  always_ff @(posedge clk_i) begin
    if (por_i || rst_i) begin
      halt_cnt_reg <= 3'h0;
    end else if (start_read) begin
      halt_cnt_reg <= HALT_READ;
    end else if (start_prog) begin
      halt_cnt_reg <= HALT_PROG;
    end else if (halt_cnt_reg != 3'h0) begin
      halt_cnt_reg <= halt_cnt_reg - 3'h1;
    end
  end

  assign bus.halt = (halt_cnt_reg != 3'h0);

  // operation snapshot taken at start, survives system reset
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      op_mode_reg <= MODE_ATOMIC;
      op_addr_reg <= '0;
      op_data_reg <= 8'h00;
    end else if (start_prog) begin
      op_mode_reg <= mode_reg;
      op_addr_reg <= addr;
      op_data_reg <= data_reg;
    end
  end

  // storage update at the end of the timed operation
  always_ff @(posedge clk_i) begin
    if (done) begin
      unique case (op_mode_reg)
        MODE_ERASE:  mem[op_addr_reg] <= ERASED_BYTE;
        MODE_WRITE:  mem[op_addr_reg] <= mem[op_addr_reg] & op_data_reg;
        MODE_ATOMIC: mem[op_addr_reg] <= op_data_reg;
        default:     mem[op_addr_reg] <= mem[op_addr_reg];
      endcase
    end
  end

  // register read mux
  always_comb begin
    unique case (bus.io_addr)
      IO_ADDR_HIGH: bus.io_rdata = {7'h00, addr_hi_reg};
      IO_ADDR_LOW:  bus.io_rdata = addr_lo_reg;
      IO_DATA:      bus.io_rdata = data_reg;
      IO_CTRL:      bus.io_rdata = ctrl_word(mode_reg, rie_reg, mpe_reg, busy, 1'b0);
    endcase
  end

  // level request, no stored flag
  assign bus.ready_irq = rie_reg && bus.gie && !busy;

endmodule : eac_device

// file: eac_asserts.sv
`timescale 1ns/1ns
module eac_asserts
  import eac_pkg::*;
#(
  parameter int ATOMIC_P = ATOMIC_CYCLES,
  parameter int SPLIT_P  = SPLIT_CYCLES
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       por_i,
  input wire logic [1:0] io_addr,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic       halt,
  input wire logic       ready_irq,
  input wire logic       gie,
  input wire logic       nvm_busy_o
);
  logic        wr_ctl;
  logic        pe_wr;
  logic        rie_q;
  logic [1:0]  mode_q;
  logic [3:0]  mpe_age;
  logic [TMR_W-1:0] run_len;
  logic        pe_clr_rd;
  assign wr_ctl    = io_wr && io_addr == IO_CTRL;
  assign pe_wr     = wr_ctl && io_wdata[CTRL_PE_BIT];
  assign pe_clr_rd = io_rd && io_addr == IO_CTRL && !io_rdata[CTRL_PE_BIT];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);
  // mirror of the control fields
  always_ff @(posedge clk_i) begin
    if (por_i || (rst_i && !nvm_busy_o)) mode_q <= MODE_RESET;
    else if (wr_ctl && !nvm_busy_o) mode_q <= io_wdata[CTRL_MODE_HI:CTRL_MODE_LO];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) rie_q <= 1'b0;
    else if (wr_ctl) rie_q <= io_wdata[CTRL_RIE_BIT];
  end
  // cycles since master enable was written
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) mpe_age <= 4'hF;
    else if (wr_ctl && io_wdata[CTRL_MPE_BIT]) mpe_age <= 4'h1;
    else if (mpe_age != 4'hF) mpe_age <= mpe_age + 4'h1;
  end
  always_ff @(posedge clk_i) begin
    run_len <= nvm_busy_o ? run_len + TMR_W'(1) : '0;
  end
  rd_halt_len_a: assert property (wr_ctl && io_wdata[CTRL_READ_BIT] && !nvm_busy_o |=> halt [*4] ##1 !halt)
    else $error("read stall length wrong");
  prog_halt_len_a: assert property ($rose(nvm_busy_o) |-> halt [*2] ##1 !halt)
    else $error("program stall length wrong");
  prog_arm_a: assert property ($rose(nvm_busy_o) |-> $past(pe_wr) && $past(mpe_age) inside {[4'h1:4'h4]}
    && $past(mode_q) != MODE_RSVD) else $error("program started without arming");
  prog_time_a: assert property ($fell(nvm_busy_o) |-> run_len == (mode_q == MODE_ATOMIC ? ATOMIC_P : SPLIT_P))
    else $error("programming time wrong for mode");
  ready_lvl_a: assert property (ready_irq == (rie_q && gie && !nvm_busy_o))
    else $error("ready request level wrong");
  high_rsvd_a: assert property (io_addr == IO_ADDR_HIGH |-> io_rdata[7:1] == 7'h00)
    else $error("address high reserved bits not zero");
  ctrl_fields_a: assert property (io_addr == IO_CTRL |-> io_rdata[7:3] == {2'h0, mode_q, rie_q})
    else $error("control fields read back wrong");
  pe_busy_a: assert property (io_addr == IO_CTRL |-> io_rdata[CTRL_PE_BIT] == nvm_busy_o)
    else $error("program enable differs from busy");
  mpe_clear_a: assert property (io_addr == IO_CTRL && mpe_age > 4'h5 |-> !io_rdata[CTRL_MPE_BIT])
    else $error("master enable not cleared");
  poll_first_a: assert property (wr_ctl && io_wdata[CTRL_READ_BIT] |-> $past(pe_clr_rd, 3))
    else $error("read strobe without idle poll");
  cover property ($fell(nvm_busy_o) && mode_q == MODE_ERASE);
  cover property ($fell(nvm_busy_o) && mode_q == MODE_WRITE);
  cover property (ready_irq);
  cover property (@(posedge clk_i) disable iff (por_i) rst_i && nvm_busy_o);
endmodule : eac_asserts

// file: eac_tb_top.sv
`timescale 1ns/1ns
module eac_tb_top;
  import eac_pkg::*;
  localparam int ATOMIC_P = 40;
  localparam int SPLIT_P  = 20;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        por_i = 1'b1;
  logic [2:0]  avs_address = 3'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        nvm_busy;
  logic [31:0] lfsr_q = 32'h695E;
  logic [31:0] rq;
  logic [63:0] note;
  logic [63:0] exp_q[$];
  logic [7:0]  mem_m[NVM_BYTES];
  logic [8:0]  bnd[4] = '{9'h000, 9'h0FF, 9'h100, 9'h1FF};
  logic [1:0]  mseq[5] = '{MODE_ATOMIC, MODE_ERASE, MODE_WRITE, MODE_WRITE, MODE_RSVD};
  logic [8:0]  adr;
  int          error_cnt = 0;
  int          n_checks = 0;

  always #10 clk_i = ~clk_i;

  eac_if u_eac_if ();
  eac_device #(.ATOMIC_CYCLES_P(ATOMIC_P), .SPLIT_CYCLES_P(SPLIT_P)) u_eac_device (.clk_i(clk_i), .rst_i(rst_i),
    .por_i(por_i), .bus(u_eac_if.dev), .nvm_busy_o(nvm_busy));
  eac_host u_eac_host (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .bus(u_eac_if.host));
  eac_asserts #(.ATOMIC_P(ATOMIC_P), .SPLIT_P(SPLIT_P)) u_eac_asserts (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
    .io_addr(u_eac_if.io_addr), .io_wr(u_eac_if.io_wr), .io_rd(u_eac_if.io_rd), .io_wdata(u_eac_if.io_wdata),
    .io_rdata(u_eac_if.io_rdata), .halt(u_eac_if.halt), .ready_irq(u_eac_if.ready_irq), .gie(u_eac_if.gie),
    .nvm_busy_o(nvm_busy));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask : chk

  // one avalon transfer; a read notes its masked expectation
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d, input logic [31:0] m,
                     output logic [31:0] q);
    int n = 0;
    @(posedge clk_i);
    if (!w) exp_q.push_back({d & m, m});
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= w ? d : 32'h0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 64) begin
      error_cnt++;
      report_and_stop();
    end
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 32'h0, q);
  endtask : wr

  task automatic idle();
    int n = 0;
    do begin
      bus(1'b0, HOST_STATUS, 32'h0, 32'h0, rq);
      n++;
    end while (rq[STAT_ENGINE_BIT] !== 1'b0 && n < 200);
    if (n >= 200) begin
      error_cnt++;
      report_and_stop();
    end
  endtask : idle

  task automatic op(input logic [8:0] a, input logic [7:0] d, input logic [2:0] c);
    idle();
    wr(HOST_ADDR, {23'h0, a});
    wr(HOST_WDATA, {24'h0, d});
    wr(HOST_CMD, {29'h0, c});
  endtask : op

  task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] md);
    op(a, d, {1'b0, md});
    if (md == MODE_ATOMIC) mem_m[a] = d;
    else if (md == MODE_ERASE) mem_m[a] = ERASED_BYTE;
    else if (md == MODE_WRITE) mem_m[a] = mem_m[a] & d;
  endtask : prog

  task automatic fetch(input logic [8:0] a);
    op(a, 8'h00, 3'h4);
    idle();
    bus(1'b0, HOST_RDATA, {24'h0, mem_m[a]}, 32'hFF, rq);
  endtask : fetch

  always @(posedge clk_i) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[31:0] != 32'h0) chk("readdata", note[63:32], avs_readdata & note[31:0]);
    end
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      adr = k < 4 ? bnd[k] : lfsr_q[8:0];
      for (int j = 0; j < 5; j++) begin
        prog(adr, lfsr_q[7:0], mseq[j]);
        fetch(adr);
        lfsr_q = lfsr(lfsr_q);
      end
    end
    for (int i = 0; i < 4; i++) begin
      wr(HOST_CONFIG, 32'(i));
      fetch(bnd[0]);
      bus(1'b0, HOST_STATUS, {29'h0, i[1] & i[0], 2'h0}, 32'h4, rq);
      bus(1'b0, HOST_CONFIG, 32'(i), 32'h3, rq);
    end
    prog(bnd[2], 8'h5A, MODE_ATOMIC);
    prog(bnd[2], 8'h00, MODE_ERASE);
    idle();
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    fetch(bnd[2]);
    for (int k = 0; k < 4; k++) fetch(bnd[k]);
    bus(1'b0, HOST_ADDR, {23'h0, bnd[3]}, 32'h1FF, rq);
    report_and_stop();
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    report_and_stop();
  end
endmodule : eac_tb_top
